// *** rtl/rcod_pkg.sv ***
// constants and types of the reference clock output divider
//
// How it works
// R1 - generator runs only while module_enable is 1, stops when it is 0
// R2 - clock reaches reference_output_pin only while pin_output_enable is 1
// R3 - four-bit base_source_select picks the base clock; 0111 and above 1000 reserved
// R4 - nonzero integer_divisor N divides the base clock by 2N
// R5 - zero integer_divisor passes the base clock through, fraction_trim ignored; the system clock source 0000 comes out at half its rate
// R6 - output period is twice divisor plus trim, in base clock periods
// R7 - divider_switch_request applies new divisor and trim, hardware clears it
// R8 - software changes divisor or trim only while divider_switch_request reads 0
// R9 - clock_request_status reads 1 while running, cleared after turn-off completes
// R10 - software leaves control low alone while status is 1
// R11 - source change only after enable cleared and status cleared
// R12 - stop_in_idle set stops the reference clock during Idle
// R13 - run_in_sleep clear disables the reference output during Sleep
// R14 - Sleep output needs run_in_sleep and a source other than 0000 or 0001
// R15 - on Sleep, oscillators power down unless kept by enables or low-power RC
// R16 - software enables a configured source before selecting it
// R17 - trim steps of 1/512 added to the half-period divisor
// R18 - output toggles each half period; all control bits reset to zero
package rcod_pkg;

  // register byte offsets
  localparam logic [3:0] RCOD_OFS_CTRL_LOW = 4'h0;
  localparam logic [3:0] RCOD_OFS_DIVISOR  = 4'h4;
  localparam logic [3:0] RCOD_OFS_TRIM     = 4'h8;

  // control low and trim field positions
  localparam int RCOD_BIT_ENABLE     = 15;
  localparam int RCOD_BIT_STOP_IDLE  = 13;
  localparam int RCOD_BIT_PIN_OE     = 12;
  localparam int RCOD_BIT_RUN_SLEEP  = 11;
  localparam int RCOD_BIT_SWITCH_REQ = 9;
  localparam int RCOD_BIT_STATUS     = 8;
  localparam int RCOD_SEL_LSB        = 0;
  localparam int RCOD_TRIM_LSB       = 7;

  // widths and reset values
  localparam int RCOD_DIV_W  = 15;
  localparam int RCOD_TRIM_W = 9;
  localparam int RCOD_SEL_W  = 4;
  localparam logic [15:0] RCOD_RESET_VALUE = 16'h0000;

  // base source codes
  localparam logic [3:0] RCOD_SRC_SYSTEM    = 4'h0;
  localparam logic [3:0] RCOD_SRC_PERIPH    = 4'h1;
  localparam logic [3:0] RCOD_SRC_PRIMARY   = 4'h2;
  localparam logic [3:0] RCOD_SRC_FAST_RC   = 4'h3;
  localparam logic [3:0] RCOD_SRC_LP_RC     = 4'h4;
  localparam logic [3:0] RCOD_SRC_SECONDARY = 4'h5;
  localparam logic [3:0] RCOD_SRC_PLL       = 4'h6;
  localparam logic [3:0] RCOD_SRC_EXT_REF   = 4'h8;

  // number of external base clocks sampled
  localparam int RCOD_NUM_EXT = 7;

  typedef enum logic [1:0] {
    GEN_OFF,
    GEN_RUN,
    GEN_STOPPING
  } rcod_state_t;

endpackage

// *** rtl/rcod_top.sv ***
// reference clock output divider with AHB-Lite register slave
`timescale 1ns/1ns

module rcod_top
  import rcod_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // base clock pins, asynchronous to sys_clk_in
  input  wire logic        instr_cycle_clk_in,
  input  wire logic        primary_osc_clk_in,
  input  wire logic        fast_rc_clk_in,
  input  wire logic        low_power_rc_clk_in,
  input  wire logic        secondary_osc_clk_in,
  input  wire logic        pll_x8_clk_in,
  input  wire logic        external_reference_input_in,
  // power mode and oscillator configuration, same clock domain
  input  wire logic        idle_mode_in,
  input  wire logic        sleep_mode_in,
  input  wire logic        primary_mode_in,
  input  wire logic        primary_osc_sleep_enable_in,
  input  wire logic        secondary_osc_enable_in,
  input  wire logic        low_power_rc_in_use_in,
  // oscillator power controls
  output logic             primary_osc_power_out,
  output logic             secondary_osc_power_out,
  // reference output pin
  output logic             reference_output_pin_out,
  output logic             reference_output_pin_oe_out
);

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic                   module_enable_reg;
  logic                   stop_in_idle_reg;
  logic                   pin_output_enable_reg;
  logic                   run_in_sleep_reg;
  logic                   divider_switch_request_reg;
  logic                   clock_request_status_reg;
  logic [RCOD_SEL_W-1:0]  base_source_select_reg;
  logic [RCOD_DIV_W-1:0]  integer_divisor_reg;
  logic [RCOD_TRIM_W-1:0] fraction_trim_reg;

  // bus pipeline
  logic                   wr_pend_reg;
  logic                   rd_pend_reg;
  logic [3:0]             addr_reg;

  // generator
  rcod_state_t            state_reg;
  logic [RCOD_SEL_W-1:0]  active_sel_reg;
  logic [RCOD_DIV_W-1:0]  active_div_reg;
  logic [RCOD_TRIM_W-1:0] active_trim_reg;
  logic [RCOD_DIV_W-1:0]  count_reg;
  logic [RCOD_TRIM_W-1:0] frac_acc_reg;
  logic                   extra_reg;
  logic                   level_reg;

  // base clock sampling
  logic [RCOD_NUM_EXT-1:0] base_meta_reg;
  logic [RCOD_NUM_EXT-1:0] base_sync_reg;
  logic [RCOD_NUM_EXT-1:0] base_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] read_value(input logic [3:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ofs)
      RCOD_OFS_CTRL_LOW: begin
        v[RCOD_BIT_ENABLE]     = module_enable_reg;
        v[RCOD_BIT_STOP_IDLE]  = stop_in_idle_reg;
        v[RCOD_BIT_PIN_OE]     = pin_output_enable_reg;
        v[RCOD_BIT_RUN_SLEEP]  = run_in_sleep_reg;
        v[RCOD_BIT_SWITCH_REQ] = divider_switch_request_reg;
        v[RCOD_BIT_STATUS]     = clock_request_status_reg;
        v[RCOD_SEL_LSB +: RCOD_SEL_W] = base_source_select_reg;
      end
      RCOD_OFS_DIVISOR: v[RCOD_DIV_W-1:0] = integer_divisor_reg;
      RCOD_OFS_TRIM:    v[RCOD_TRIM_LSB +: RCOD_TRIM_W] = fraction_trim_reg;
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // map a source code to its sampled clock index; system clock and reserved give none
  function automatic logic [3:0] src_index(input logic [RCOD_SEL_W-1:0] sel);
    logic [3:0] idx;
    idx = 4'hF;
    unique case (sel)
      RCOD_SRC_PERIPH:    idx = 4'h0;
      RCOD_SRC_PRIMARY:   idx = 4'h1;
      RCOD_SRC_FAST_RC:   idx = 4'h2;
      RCOD_SRC_LP_RC:     idx = 4'h3;
      RCOD_SRC_SECONDARY: idx = 4'h4;
      RCOD_SRC_PLL:       idx = 4'h5;
      RCOD_SRC_EXT_REF:   idx = 4'h6;
      default:            idx = 4'hF;
    endcase
    return idx;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait, reads take one so they see a
  // write committed in the cycle before

  logic accept;
  logic wr_cycle;
  assign accept   = hsel_in & hready_in & htrans_in[1];
  assign wr_cycle = wr_pend_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 4'h0;
    end else begin
      wr_pend_reg <= accept & hwrite_in;
      rd_pend_reg <= accept & ~hwrite_in;
      if (accept) begin
        addr_reg <= haddr_in[3:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      hreadyout_out <= 1'b1;
      hrdata_out    <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hreadyout_out <= 1'b1;
      hrdata_out    <= read_value(addr_reg);
    end else begin
      hreadyout_out <= ~(accept & ~hwrite_in);
    end
  end

  // every response is OKAY, unmapped reads give zero and writes are dropped
  always_ff @(posedge sys_clk_in) begin
    hresp_out <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      module_enable_reg      <= RCOD_RESET_VALUE[RCOD_BIT_ENABLE]; // R18
      stop_in_idle_reg       <= RCOD_RESET_VALUE[RCOD_BIT_STOP_IDLE];
      pin_output_enable_reg  <= RCOD_RESET_VALUE[RCOD_BIT_PIN_OE];
      run_in_sleep_reg       <= RCOD_RESET_VALUE[RCOD_BIT_RUN_SLEEP];
      base_source_select_reg <= RCOD_RESET_VALUE[RCOD_SEL_W-1:0];
      integer_divisor_reg    <= RCOD_RESET_VALUE[RCOD_DIV_W-1:0];
      fraction_trim_reg      <= RCOD_RESET_VALUE[RCOD_TRIM_W-1:0];
    end else if (wr_cycle) begin
      if (addr_reg == RCOD_OFS_CTRL_LOW) begin
        module_enable_reg      <= hwdata_in[RCOD_BIT_ENABLE];
        stop_in_idle_reg       <= hwdata_in[RCOD_BIT_STOP_IDLE];
        pin_output_enable_reg  <= hwdata_in[RCOD_BIT_PIN_OE];
        run_in_sleep_reg       <= hwdata_in[RCOD_BIT_RUN_SLEEP];
        base_source_select_reg <= hwdata_in[RCOD_SEL_LSB +: RCOD_SEL_W];
      end
      if (addr_reg == RCOD_OFS_DIVISOR) begin
        integer_divisor_reg <= hwdata_in[RCOD_DIV_W-1:0];
      end
      if (addr_reg == RCOD_OFS_TRIM) begin
        fraction_trim_reg <= hwdata_in[RCOD_TRIM_LSB +: RCOD_TRIM_W];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // base clock sampling and tick selection

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      base_meta_reg <= '0;
      base_sync_reg <= '0;
      base_prev_reg <= '0;
    end else begin
      base_meta_reg <= {external_reference_input_in, pll_x8_clk_in,
                        secondary_osc_clk_in, low_power_rc_clk_in,
                        fast_rc_clk_in, primary_osc_clk_in, instr_cycle_clk_in};
      base_sync_reg <= base_meta_reg;
      base_prev_reg <= base_sync_reg;
    end
  end

  logic [3:0] idx;
  logic       base_tick;
  logic       base_level;

  // system clock counts one base period per sys_clk cycle; reserved codes stall
  always_comb begin
    idx        = src_index(active_sel_reg); // R3
    base_tick  = 1'b0;
    base_level = 1'b0;
    if (active_sel_reg == RCOD_SRC_SYSTEM) begin
      base_tick  = 1'b1;
      base_level = ~level_reg;
    end else if (idx != 4'hF) begin
      base_tick  = base_sync_reg[idx[2:0]] & ~base_prev_reg[idx[2:0]];
      base_level = base_sync_reg[idx[2:0]];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // run gating by enable and power modes

  logic run_req;
  logic sleep_block;
  assign sleep_block = sleep_mode_in & (~run_in_sleep_reg
                       | (base_source_select_reg == RCOD_SRC_SYSTEM)
                       | (base_source_select_reg == RCOD_SRC_PERIPH)); // R13 R14
  assign run_req = module_enable_reg // R1
                 & ~(idle_mode_in & stop_in_idle_reg) // R12
                 & ~sleep_block;

  //////////////////////////////////////////////////////////////////////////////
  // divider

  logic                 pass_through;
  logic                 boundary;
  logic [RCOD_DIV_W:0]  target;
  logic [RCOD_DIV_W:0]  count_inc;
  logic [RCOD_TRIM_W:0] frac_sum;

  assign pass_through = (active_div_reg == '0); // R5
  assign target       = {1'b0, active_div_reg} + {{RCOD_DIV_W{1'b0}}, extra_reg}; // R6
  assign count_inc    = {1'b0, count_reg} + {{RCOD_DIV_W{1'b0}}, 1'b1};
  assign boundary     = base_tick & ~pass_through & (count_inc >= target); // R4 R18
  assign frac_sum     = {1'b0, frac_acc_reg} + {1'b0, active_trim_reg}; // R17

  // a pending switch takes effect at a half-period boundary, while off, or at once in pass-through
  logic apply_switch;
  assign apply_switch = divider_switch_request_reg
                      & ((state_reg == GEN_OFF) | boundary | pass_through); // R7

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      divider_switch_request_reg <= 1'b0;
    end else if (wr_cycle & (addr_reg == RCOD_OFS_CTRL_LOW)
                 & hwdata_in[RCOD_BIT_SWITCH_REQ]) begin
      divider_switch_request_reg <= 1'b1; // software set wins over the clear
    end else if (apply_switch) begin
      divider_switch_request_reg <= 1'b0; // R7
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      active_div_reg  <= '0;
      active_trim_reg <= '0;
    end else if (apply_switch | (state_reg == GEN_OFF)) begin
      active_div_reg  <= integer_divisor_reg;
      active_trim_reg <= fraction_trim_reg;
    end
  end

  // source is only taken over while stopped, so a live change cannot glitch
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      active_sel_reg <= '0;
    end else if (state_reg == GEN_OFF) begin
      active_sel_reg <= base_source_select_reg; // R11
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      count_reg    <= '0;
      frac_acc_reg <= '0;
      extra_reg    <= 1'b0;
      level_reg    <= 1'b0;
    end else if (state_reg == GEN_OFF) begin
      count_reg    <= '0;
      frac_acc_reg <= '0;
      extra_reg    <= 1'b0;
      level_reg    <= 1'b0;
    end else if (pass_through) begin
      level_reg <= base_level; // R5
      count_reg <= '0;
    end else if (boundary) begin
      level_reg    <= ~level_reg; // R18
      count_reg    <= '0;
      frac_acc_reg <= frac_sum[RCOD_TRIM_W-1:0];
      extra_reg    <= frac_sum[RCOD_TRIM_W]; // R6 R17
    end else if (base_tick) begin
      count_reg <= count_inc[RCOD_DIV_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // turn-on and turn-off handshake

  // stopping waits for the output to sit low so the last pulse is never cut
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_reg                <= GEN_OFF;
      clock_request_status_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        GEN_OFF: begin
          if (run_req) begin
            state_reg                <= GEN_RUN;
            clock_request_status_reg <= 1'b1; // R9
          end
        end
        GEN_RUN: begin
          if (!run_req) begin
            state_reg <= GEN_STOPPING;
          end
        end
        GEN_STOPPING: begin
          if (!level_reg) begin
            state_reg                <= GEN_OFF;
            clock_request_status_reg <= 1'b0; // R9
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin and oscillator power outputs

  logic osc_keep;
  assign osc_keep = (primary_mode_in & primary_osc_sleep_enable_in)
                  | secondary_osc_enable_in | low_power_rc_in_use_in;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      reference_output_pin_out    <= 1'b0;
      reference_output_pin_oe_out <= 1'b0;
      primary_osc_power_out       <= 1'b1;
      secondary_osc_power_out     <= 1'b1;
    end else begin
      reference_output_pin_out    <= level_reg & pin_output_enable_reg
                                   & (state_reg != GEN_OFF); // R2
      reference_output_pin_oe_out <= pin_output_enable_reg; // R2
      primary_osc_power_out       <= ~sleep_mode_in | osc_keep; // R15
      secondary_osc_power_out     <= ~sleep_mode_in | osc_keep; // R15
    end
  end

endmodule

// *** dv/rcod_properties.sv ***
// port-level checks of the reference clock output divider
`timescale 1ns/1ns
module rcod_properties (
  // clock, reset and bus
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        hsel_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out,
  // power modes and pins
  input wire logic        sleep_mode_in,
  input wire logic        primary_mode_in,
  input wire logic        primary_osc_sleep_enable_in,
  input wire logic        secondary_osc_enable_in,
  input wire logic        low_power_rc_in_use_in,
  input wire logic        primary_osc_power_out,
  input wire logic        secondary_osc_power_out,
  input wire logic        reference_output_pin_out,
  input wire logic        reference_output_pin_oe_out
);
  logic rd_take;
  logic keep;
  assign rd_take = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  assign keep = (primary_mode_in && primary_osc_sleep_enable_in) || secondary_osc_enable_in
    || low_power_rc_in_use_in;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_wait_state;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  sequence s_osc_off;
    !primary_osc_power_out && !secondary_osc_power_out;
  endsequence
  a_resp_okay: assert property (!hresp_out)
    else $error("slave response not okay");
  a_read_wait: assert property (rd_take |=> s_wait_state)
    else $error("read data phase not one wait state");
  a_write_no_wait: assert property (hsel_in && hready_in && htrans_in[1] && hwrite_in
    |=> hreadyout_out) else $error("write data phase stalled");
  a_wait_cause: assert property (!hreadyout_out |-> $past(rd_take))
    else $error("wait state without a read");
  a_rdata_hold: assert property ($changed(hrdata_out) |-> !$past(hreadyout_out))
    else $error("read data changed outside a read");
  a_pin_gated: assert property ((!reference_output_pin_oe_out)[*2] |-> !reference_output_pin_out)
    else $error("pin driven while output disabled");
  a_osc_power_down: assert property (sleep_mode_in && !keep |=> s_osc_off)
    else $error("oscillators kept powered in sleep");
  a_osc_power_up: assert property (!sleep_mode_in || keep |=> primary_osc_power_out
    && secondary_osc_power_out) else $error("oscillator powered down");
endmodule

bind rcod_top rcod_properties u_props (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .hrdata_out(hrdata_out), .sleep_mode_in(sleep_mode_in),
  .primary_mode_in(primary_mode_in), .primary_osc_sleep_enable_in(primary_osc_sleep_enable_in),
  .secondary_osc_enable_in(secondary_osc_enable_in),
  .low_power_rc_in_use_in(low_power_rc_in_use_in),
  .primary_osc_power_out(primary_osc_power_out),
  .secondary_osc_power_out(secondary_osc_power_out),
  .reference_output_pin_out(reference_output_pin_out),
  .reference_output_pin_oe_out(reference_output_pin_oe_out));

// *** dv/rcod_ext_sink.sv ***
// far-side device model: counts reference clock edges arriving on the pin
`timescale 1ns/1ns
module rcod_ext_sink (
  // pin from the divider
  input  wire logic pin_in,
  input  wire logic oe_in,
  // observed clock
  output int        edges_out,
  output real       last_out
);
  int  edge_count = 0;
  real edge_time  = 0.0;
  assign edges_out = edge_count;
  assign last_out  = edge_time;
  // an undriven pin clocks nothing downstream
  always @(posedge pin_in) begin
    if (oe_in) begin
      edge_count <= edge_count + 1;
      edge_time  <= $realtime;
    end
  end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench of the reference clock output divider
`timescale 1ns/1ns
module tb_top
  import rcod_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle = 1'b0;
  logic        sleep = 1'b0, pmode = 1'b0, pen = 1'b0, sen = 1'b0, lpen = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [4:0]  bc = 5'h00;
  logic        hresp, ppow, spow, pin, oe;
  wire         hready;
  int          edges, fails = 0, cmp_count = 0;
  real         last_t;

  always #10 clk = ~clk;
  // base clocks on a 31 ns step, unrelated in phase to the system clock
  // every base clock runs from time zero, so each source is live before it is selected
  always #31 bc = bc + 5'h01;

  rcod_top u_dut (
    .sys_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .instr_cycle_clk_in(bc[0]), .primary_osc_clk_in(bc[1]), .fast_rc_clk_in(bc[2]),
    .low_power_rc_clk_in(bc[3]), .secondary_osc_clk_in(bc[4]), .pll_x8_clk_in(bc[0]),
    .external_reference_input_in(bc[1]), .idle_mode_in(idle), .sleep_mode_in(sleep),
    .primary_mode_in(pmode), .primary_osc_sleep_enable_in(pen),
    .secondary_osc_enable_in(sen), .low_power_rc_in_use_in(lpen),
    .primary_osc_power_out(ppow), .secondary_osc_power_out(spow),
    .reference_output_pin_out(pin), .reference_output_pin_oe_out(oe));
  rcod_ext_sink u_sink (.pin_in(pin), .oe_in(oe), .edges_out(edges), .last_out(last_t));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    // no cycle count is assumed: only the watchdog ends a stuck wait
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {28'h0000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, {16'h0000, d}, r);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h00000000, r);
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    do begin
      rd(RCOD_OFS_CTRL_LOW, r);
    end while (r[b] !== v);
  endtask

  // source and mode changes only with the generator turned off;
  // on is 0 where idle or sleep keeps an enabled generator from starting
  task automatic run(input logic [15:0] c, input logic on);
    wr(RCOD_OFS_CTRL_LOW, 16'h0000);
    poll(RCOD_BIT_STATUS, 1'b0);
    wr(RCOD_OFS_CTRL_LOW, c);
    if (c[RCOD_BIT_ENABLE]) poll(RCOD_BIT_STATUS, on);
  endtask

  task automatic wait_edges(input int k);
    int e;
    e = edges;
    while (edges < e + k) begin
      @(posedge clk);
    end
  endtask

  // mean of four periods absorbs the synchroniser jitter
  task automatic period_is(input string nm, input real exp);
    real t0;
    real p;
    wait_edges(1);
    t0 = last_t;
    wait_edges(4);
    p = (last_t - t0) / 4.0;
    check(nm, 32'(p > exp - 10.0 && p < exp + 10.0), 32'h1);
  endtask

  task automatic no_edges(input string nm);
    int e;
    e = edges;
    repeat (80) @(posedge clk);
    check(nm, 32'(edges - e), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] r;
    check("pin at reset", {30'h0, pin, oe}, 32'h0);
    for (int i = 0; i < 16; i += 4) begin
      rd(4'(i), r);
      check("reset value", r, 32'h0);
    end
  endtask

  task automatic t_regs();
    logic [31:0] r;
    wr(RCOD_OFS_DIVISOR, 16'hFFFF);
    rd(RCOD_OFS_DIVISOR, r);
    check("divisor", r, 32'h00007FFF);
    wr(RCOD_OFS_TRIM, 16'hFFFF);
    rd(RCOD_OFS_TRIM, r);
    check("trim", r, 32'h0000FF80);
    wr(RCOD_OFS_CTRL_LOW, 16'h7FF7);
    rd(RCOD_OFS_CTRL_LOW, r);
    check("control", r, 32'h00003807);
    wr(4'hC, 16'hFFFF);
    rd(4'hC, r);
    check("unmapped", r, 32'h0);
  endtask

  task automatic t_divide();
    logic [15:0] dv [4] = '{16'h0001, 16'h0003, 16'h0000, 16'h0002};
    logic [15:0] tr [4] = '{16'h0000, 16'h0000, 16'h8000, 16'h8000};
    real         ex [4] = '{40.0, 120.0, 40.0, 100.0};
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      run(16'h0000, 1'b0);
      wr(RCOD_OFS_DIVISOR, dv[i]);
      wr(RCOD_OFS_TRIM, tr[i]);
      run(16'h9000, 1'b1);
      rd(RCOD_OFS_CTRL_LOW, r);
      check("status on", r, 32'h00009100);
      period_is("divided period", ex[i]);
    end
  endtask

  task automatic t_sources();
    logic [3:0] sc [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
    real        bp [8] = '{20.0, 62.0, 124.0, 248.0, 496.0, 992.0, 62.0, 124.0};
    logic [31:0] r;
    run(16'h0000, 1'b0);
    wr(RCOD_OFS_DIVISOR, 16'h0001);
    wr(RCOD_OFS_TRIM, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      run({12'h900, sc[i]}, 1'b1);
      period_is("source period", 2.0 * bp[i]);
    end
    run(16'h9007, 1'b1);
    no_edges("reserved source");
    run(16'h1000, 1'b0);
    rd(RCOD_OFS_CTRL_LOW, r);
    check("status off", r, 32'h00001000);
    no_edges("disabled");
  endtask

  task automatic t_switch();
    logic [31:0] r;
    wr(RCOD_OFS_DIVISOR, 16'h0002);
    run(16'h9000, 1'b1);
    period_is("before switch", 80.0);
    wr(RCOD_OFS_DIVISOR, 16'h0004);
    wr(RCOD_OFS_CTRL_LOW, 16'h9200);
    poll(RCOD_BIT_SWITCH_REQ, 1'b0);
    rd(RCOD_OFS_CTRL_LOW, r);
    check("switch done", r, 32'h00009100);
    period_is("after switch", 160.0);
  endtask

  task automatic t_modes();
    logic [31:0] r;
    run(16'h8000, 1'b1);
    no_edges("pin disabled");
    check("pin low", {31'h0, pin}, 32'h0);
    idle <= 1'b1;
    run(16'hB000, 1'b0);
    no_edges("idle stop");
    rd(RCOD_OFS_CTRL_LOW, r);
    check("idle status", r, 32'h0000B000);
    run(16'h9000, 1'b1);
    period_is("idle run", 160.0);
    idle <= 1'b0;
    wr(RCOD_OFS_DIVISOR, 16'h0001);
    sleep <= 1'b1;
    sen <= 1'b1;
    run(16'h9002, 1'b0);
    no_edges("sleep stop");
    run(16'h9802, 1'b1);
    period_is("sleep run", 248.0);
    run(16'h9800, 1'b0);
    no_edges("sleep system source");
    check("osc kept", {30'h0, ppow, spow}, 32'h3);
    sen <= 1'b0;
    repeat (2) @(posedge clk);
    check("osc down", {30'h0, ppow, spow}, 32'h0);
    lpen <= 1'b1;
    repeat (2) @(posedge clk);
    check("osc low_power_rc_oscillator keep", {30'h0, ppow, spow}, 32'h3);
    sleep <= 1'b0;
  endtask

  task automatic stop_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_divide();
    t_sources();
    t_switch();
    t_modes();
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
